// ---- rtl/trd_pkg.sv ----
/*
  trd_pkg: shared types and constants for the table-reference and
  redundant-load sequencing block of a 4-bit core.
  assumes: the fetch path pre-decodes every byte it delivers into a kind code.
*/
package trd_pkg;

  // program address width and the table-reference look-up area
  localparam int TRD_ADDR_W = 14;
  localparam logic [13:0] TRD_TABLE_LO = 14'h0020;
  localparam logic [13:0] TRD_TABLE_HI = 14'h007F;
  localparam logic [13:0] TRD_ONE_BYTE = 14'h0001;
  localparam int TRD_MSB_POS = 15;

  // instruction classes known to the sequencer
  typedef enum logic [3:0] {
    TRD_K_OTHER = 4'h0,
    TRD_K_LD_ACC_IMM = 4'h1,
    TRD_K_LD_EXT_ACC_IMM = 4'h2,
    TRD_K_LD_PTR_IMM = 4'h3,
    TRD_K_REF = 4'h4,
    TRD_K_EXCHANGE_DIRECT = 4'h5,
    TRD_K_TABLE_JUMP = 4'h6,
    TRD_K_TABLE_CALL = 4'h7
  } trd_kind_t;

  // redundancy run being tracked
  typedef enum logic [1:0] {
    TRD_RUN_NONE = 2'h0,
    TRD_RUN_ACC = 2'h1,
    TRD_RUN_PTR = 2'h2
  } trd_run_t;

  // sequencer states, gray along idle-fetch-first-second
  typedef enum logic [1:0] {
    TRD_ST_IDLE = 2'h0,
    TRD_ST_FETCH = 2'h1,
    TRD_ST_FIRST = 2'h3,
    TRD_ST_SECOND = 2'h2
  } trd_state_t;

  // one main-stream instruction from the fetch path
  typedef struct packed {
    trd_kind_t kind;
    logic [15:0] code;
    logic [13:0] addr;
    logic [13:0] target;
  } trd_ins_t;

  // one table entry read from the look-up area
  typedef struct packed {
    trd_kind_t first_kind;
    trd_kind_t second_kind;
    logic pair;
    logic [15:0] code;
    logic [13:0] target;
  } trd_entry_t;

  // instruction handed to the execution unit
  typedef struct packed {
    trd_kind_t kind;
    logic [15:0] code;
  } trd_exec_t;

endpackage

// ---- rtl/trd_sequencer.sv ----
/*
  trd_sequencer: executes table-reference entries and suppresses
  redundant immediate loads before they reach the execution unit.
  assumes: fetch path pre-decodes kinds and holds its word while in_ready is
  low; table reads answer on tbl_valid some cycles after tbl_req; the
  execution unit takes one instruction a cycle and reports skip in that cycle.
*/
`timescale 1ns/1ps
module trd_sequencer
  import trd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // main instruction stream
  input wire logic in_valid,
  input wire trd_ins_t in_ins,
  output logic in_ready_reg,
  // look-up area read port
  output logic tbl_req_reg,
  output logic [13:0] tbl_addr_reg,
  input wire logic tbl_valid,
  input wire trd_entry_t tbl_ent,
  // execution unit
  output logic ex_valid_reg,
  output trd_exec_t ex_ins_reg,
  output logic ex_nop_reg,
  output logic ex_from_tbl_reg,
  input wire logic ex_skip,
  // program flow
  output logic resume_reg,
  output logic [13:0] resume_addr_reg,
  output logic branch_reg,
  output logic [13:0] branch_addr_reg,
  output logic call_push_reg,
  output logic [13:0] ret_addr_reg,
  output logic ref_fault_reg
);

  // group of a kind for redundancy tracking
  function automatic trd_run_t group_of(input trd_kind_t k);
    if (k == TRD_K_LD_ACC_IMM || k == TRD_K_LD_EXT_ACC_IMM)
      return TRD_RUN_ACC;
    if (k == TRD_K_LD_PTR_IMM)
      return TRD_RUN_PTR;
    return TRD_RUN_NONE;
  endfunction

  // redundant when it joins the run already open
  function automatic logic is_redundant(input trd_kind_t k, input trd_run_t r);
    return (group_of(k) != TRD_RUN_NONE) && (group_of(k) == r);
  endfunction

  trd_state_t state_reg, state_next;
  trd_run_t run_reg, run_next;
  trd_entry_t ent_reg, ent_next;
  logic skip_pend_reg, skip_pend_next;
  logic [13:0] ref_next_reg, ref_next_next;
  logic in_ready_next, tbl_req_next, ex_valid_next, ex_nop_next, ex_from_tbl_next;
  logic resume_next, branch_next, call_push_next, ref_fault_next;
  logic [13:0] tbl_addr_next, branch_addr_next, resume_addr_next;
  trd_exec_t ex_ins_next;

  // decode of the current request
  wire took_main = (state_reg == TRD_ST_IDLE) && in_valid && in_ready_reg;
  wire skip_now = skip_pend_reg || (ex_valid_reg && !ex_nop_reg && ex_skip);
  wire ref_addr_ok = (in_ins.target >= TRD_TABLE_LO) && (in_ins.target <= TRD_TABLE_HI)
    && !in_ins.target[0];
  wire first_bad = (tbl_ent.first_kind == TRD_K_EXCHANGE_DIRECT)
    || (tbl_ent.pair && !tbl_ent.code[TRD_MSB_POS]);
  wire first_pseudo = (tbl_ent.first_kind == TRD_K_TABLE_JUMP)
    || (tbl_ent.first_kind == TRD_K_TABLE_CALL);
  wire [13:0] after_ref = in_ins.addr + TRD_ONE_BYTE;

  // next-state and output decisions
  always_comb
  begin
    state_next = state_reg;
    run_next = run_reg;
    ent_next = ent_reg;
    ref_next_next = ref_next_reg;
    skip_pend_next = skip_now;
    tbl_req_next = 1'b0;
    tbl_addr_next = tbl_addr_reg;
    ex_valid_next = 1'b0;
    ex_ins_next = ex_ins_reg;
    ex_nop_next = 1'b0;
    ex_from_tbl_next = 1'b0;
    resume_next = 1'b0;
    resume_addr_next = resume_addr_reg;
    branch_next = 1'b0;
    branch_addr_next = branch_addr_reg;
    call_push_next = 1'b0;
    ref_fault_next = 1'b0;
    case (state_reg)
      TRD_ST_IDLE:
      begin
        if (took_main)
        begin
          skip_pend_next = 1'b0;
          if (skip_now)
          begin
            // skipped word, a reference included, is passed on as nop
            ex_valid_next = 1'b1;
            ex_ins_next = '{kind: in_ins.kind, code: in_ins.code};
            ex_nop_next = 1'b1;
            run_next = TRD_RUN_NONE;
          end
          else if (in_ins.kind == TRD_K_REF)
          begin
            run_next = TRD_RUN_NONE;
            ref_next_next = after_ref;
            if (ref_addr_ok)
            begin
              tbl_req_next = 1'b1;
              tbl_addr_next = in_ins.target;
              state_next = TRD_ST_FETCH;
            end
            else
            begin
              ref_fault_next = 1'b1;
              resume_next = 1'b1;
              resume_addr_next = after_ref;
            end
          end
          else
          begin
            ex_valid_next = 1'b1;
            ex_ins_next = '{kind: in_ins.kind, code: in_ins.code};
            ex_nop_next = is_redundant(in_ins.kind, run_reg);
            run_next = group_of(in_ins.kind);
          end
        end
      end
      TRD_ST_FETCH:
      begin
        if (tbl_valid)
        begin
          ent_next = tbl_ent;
          if (first_bad)
          begin
            ref_fault_next = 1'b1;
            resume_next = 1'b1;
            resume_addr_next = ref_next_reg;
            state_next = TRD_ST_IDLE;
          end
          else if (first_pseudo)
          begin
            branch_next = 1'b1;
            branch_addr_next = tbl_ent.target;
            call_push_next = (tbl_ent.first_kind == TRD_K_TABLE_CALL);
            state_next = TRD_ST_IDLE;
          end
          else
          begin
            // first referenced instruction runs whole
            ex_valid_next = 1'b1;
            ex_ins_next = '{kind: tbl_ent.first_kind, code: tbl_ent.code};
            ex_from_tbl_next = 1'b1;
            run_next = group_of(tbl_ent.first_kind);
            state_next = tbl_ent.pair ? TRD_ST_SECOND : TRD_ST_FIRST;
          end
        end
      end
      TRD_ST_SECOND:
      begin
        // second one-byte instruction of a pair
        ex_valid_next = 1'b1;
        ex_ins_next = '{kind: ent_reg.second_kind, code: ent_reg.code};
        ex_from_tbl_next = 1'b1;
        ex_nop_next = is_redundant(ent_reg.second_kind, run_reg);
        run_next = group_of(ent_reg.second_kind);
        state_next = TRD_ST_FIRST;
      end
      TRD_ST_FIRST:
      begin
        resume_next = 1'b1;
        resume_addr_next = ref_next_reg;
        state_next = TRD_ST_IDLE;
      end
      default:
        state_next = TRD_ST_IDLE;
    endcase
    in_ready_next = (state_next == TRD_ST_IDLE);
  end

  // state and output registers
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_reg <= TRD_ST_IDLE;
      run_reg <= TRD_RUN_NONE;
      ent_reg <= '0;
      skip_pend_reg <= 1'b0;
      ref_next_reg <= '0;
      in_ready_reg <= 1'b0;
      tbl_req_reg <= 1'b0;
      tbl_addr_reg <= TRD_TABLE_LO;
      ex_valid_reg <= 1'b0;
      ex_ins_reg <= '0;
      ex_nop_reg <= 1'b0;
      ex_from_tbl_reg <= 1'b0;
      resume_reg <= 1'b0;
      resume_addr_reg <= '0;
      branch_reg <= 1'b0;
      branch_addr_reg <= '0;
      call_push_reg <= 1'b0;
      ret_addr_reg <= '0;
      ref_fault_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      run_reg <= run_next;
      ent_reg <= ent_next;
      skip_pend_reg <= skip_pend_next;
      ref_next_reg <= ref_next_next;
      in_ready_reg <= in_ready_next;
      tbl_req_reg <= tbl_req_next;
      tbl_addr_reg <= tbl_addr_next;
      ex_valid_reg <= ex_valid_next;
      ex_ins_reg <= ex_ins_next;
      ex_nop_reg <= ex_nop_next;
      ex_from_tbl_reg <= ex_from_tbl_next;
      resume_reg <= resume_next;
      resume_addr_reg <= resume_addr_next;
      branch_reg <= branch_next;
      branch_addr_reg <= branch_addr_next;
      call_push_reg <= call_push_next;
      ret_addr_reg <= call_push_next ? ref_next_reg : ret_addr_reg;
      ref_fault_reg <= ref_fault_next;
    end
  end

  // checks on the sequencing
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  table_range_a: assert property (tbl_req_reg |-> tbl_addr_reg >= TRD_TABLE_LO
    && tbl_addr_reg <= TRD_TABLE_HI && !tbl_addr_reg[0]) else $error("table read out of area");
  pair_issue_a: assert property (state_reg == TRD_ST_FETCH && tbl_valid && tbl_ent.pair
    && !first_bad && !first_pseudo |=> ex_valid_reg ##1 ex_valid_reg ##1 resume_reg)
    else $error("pair not issued twice");
  pseudo_branch_a: assert property (state_reg == TRD_ST_FETCH && tbl_valid && first_pseudo
    && !first_bad |=> branch_reg && !ex_valid_reg && branch_addr_reg == $past(tbl_ent.target))
    else $error("pseudo entry did not branch");
  ref_hold_a: assert property (took_main && !skip_now && in_ins.kind == TRD_K_REF
    && ref_addr_ok |=> !in_ready_reg && tbl_req_reg) else $error("stream not held");
  resume_point_a: assert property (took_main && !skip_now && in_ins.kind == TRD_K_REF
    |=> ref_next_reg == $past(in_ins.addr) + TRD_ONE_BYTE) else $error("bad resume point");
  call_return_a: assert property (call_push_reg |-> branch_reg && ret_addr_reg == ref_next_reg)
    else $error("call without return point");
  skip_ref_a: assert property (took_main && skip_now |=> ex_nop_reg && !tbl_req_reg)
    else $error("skipped word not cancelled");
  bad_entry_a: assert property (state_reg == TRD_ST_FETCH && tbl_valid && first_bad
    |=> ref_fault_reg && !ex_valid_reg) else $error("bad entry executed");
  acc_suppress_a: assert property (took_main && !skip_now && run_reg == TRD_RUN_ACC
    && group_of(in_ins.kind) == TRD_RUN_ACC |=> ex_nop_reg) else $error("acc load kept");
  ptr_suppress_a: assert property (took_main && !skip_now && run_reg == TRD_RUN_PTR
    && in_ins.kind == TRD_K_LD_PTR_IMM |=> ex_nop_reg) else $error("pointer load kept");
  group_split_a: assert property (took_main && !skip_now && run_reg != TRD_RUN_ACC
    && group_of(in_ins.kind) == TRD_RUN_ACC |=> !ex_nop_reg) else $error("load wrongly cut");
  ref_cancel_a: assert property (state_reg == TRD_ST_FETCH && tbl_valid && !first_bad
    && !first_pseudo |=> ex_valid_reg && !ex_nop_reg) else $error("referenced load cut");

  pair_run_c: cover property (ex_valid_reg && ex_from_tbl_reg ##1 ex_valid_reg && ex_from_tbl_reg);
  call_entry_c: cover property (call_push_reg);
  suppress_run_c: cover property (ex_nop_reg ##1 ex_nop_reg);
  skip_after_ref_c: cover property (resume_reg ##[1:8] (ex_valid_reg && ex_nop_reg));

endmodule

// ---- testbench/trd_far_model.sv ----
/*
  trd_far_model: look-up area memory and execution-unit skip source.
  assumes: one table request at a time, address held between requests.
*/
`timescale 1ns/1ps
module trd_far_model
  import trd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // table port
  input wire logic tbl_req_reg,
  input wire logic [13:0] tbl_addr_reg,
  output logic tbl_valid,
  output trd_entry_t tbl_ent,
  // execution unit
  input wire logic ex_valid_reg,
  input wire trd_exec_t ex_ins_reg,
  input wire logic ex_nop_reg,
  input wire trd_kind_t skip_kind,
  output logic ex_skip
);
  logic [1:0] wait_reg;
  // entries sit at even addresses; the pair is load then count-and-skip
  function automatic trd_entry_t ent(input logic [7:0] a);
    case (a)
      8'h20: ent = '{TRD_K_LD_EXT_ACC_IMM, TRD_K_OTHER, 1'b0, 16'hA530, 14'h0};
      8'h22: ent = '{TRD_K_LD_ACC_IMM, TRD_K_OTHER, 1'b1, 16'h9A12, 14'h0};
      8'h24: ent = '{TRD_K_TABLE_JUMP, TRD_K_OTHER, 1'b0, 16'h0, 14'h1234};
      8'h26: ent = '{TRD_K_TABLE_CALL, TRD_K_OTHER, 1'b0, 16'h0, 14'h0456};
      8'h28: ent = '{TRD_K_EXCHANGE_DIRECT, TRD_K_OTHER, 1'b0, 16'h0, 14'h0};
      default: ent = '{TRD_K_LD_ACC_IMM, TRD_K_OTHER, 1'b1, 16'h1A12, 14'h0};
    endcase
  endfunction
  // skip raised by one chosen kind of executed instruction
  assign ex_skip = ex_valid_reg & ~ex_nop_reg & (ex_ins_reg.kind == skip_kind);
  // answer due this edge: count has run down and no new request
  wire answer_now = !tbl_req_reg && (wait_reg == 2'h1);
  // slow or prompt answer; released bus shows inverted data
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wait_reg <= 2'h0;
      tbl_valid <= 1'b0;
      tbl_ent <= '0;
    end
    else
    begin
      tbl_valid <= answer_now;
      tbl_ent <= answer_now ? ent(tbl_addr_reg[7:0]) : ~tbl_ent;
      if (tbl_req_reg)
        wait_reg <= tbl_addr_reg[2] ? 2'h1 : 2'h3;
      else if (wait_reg != 2'h0)
        wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule

// ---- testbench/tb_table_reference_redundancy_decoder.sv ----
/*
  tb_table_reference_redundancy_decoder: scenario bench for trd_sequencer.
  assumes: trd_far_model answers table reads and raises skips.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_table_reference_redundancy_decoder
  import trd_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic in_valid = 1'b0;
  trd_ins_t in_ins = '0;
  trd_kind_t skip_kind = TRD_K_TABLE_CALL;
  logic in_ready_reg, tbl_req_reg, tbl_valid, ex_valid_reg, ex_nop_reg;
  logic ex_from_tbl_reg, ex_skip, resume_reg, branch_reg, call_push_reg, ref_fault_reg;
  logic [13:0] tbl_addr_reg, resume_addr_reg, branch_addr_reg, ret_addr_reg;
  trd_entry_t tbl_ent;
  trd_exec_t ex_ins_reg;
  logic [31:0] log_q[$];
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  always #12.5 mclk = ~mclk;

  trd_sequencer u_dut (.mclk, .sys_rst, .in_valid, .in_ins, .in_ready_reg, .tbl_req_reg,
    .tbl_addr_reg, .tbl_valid, .tbl_ent, .ex_valid_reg, .ex_ins_reg, .ex_nop_reg,
    .ex_from_tbl_reg, .ex_skip, .resume_reg, .resume_addr_reg, .branch_reg,
    .branch_addr_reg, .call_push_reg, .ret_addr_reg, .ref_fault_reg);
  trd_far_model u_far (.mclk, .sys_rst, .tbl_req_reg, .tbl_addr_reg, .tbl_valid,
    .tbl_ent, .ex_valid_reg, .ex_ins_reg, .ex_nop_reg, .skip_kind, .ex_skip);

  // event words: group, flags, instruction code and kind, or an address
  function automatic logic [31:0] ex_e(input logic n, input logic t, input trd_kind_t k,
    input logic [15:0] c = 16'h0);
    ex_e = {4'h1, 6'h0, n, t, c, k};
  endfunction
  function automatic logic [31:0] ad_e(input logic [3:0] g, input logic [13:0] a);
    ad_e = {g, 14'h0, a};
  endfunction

  // log of output events, plus the hang limit
  always @(posedge mclk)
  begin
    cyc++;
    if (!sys_rst && tbl_req_reg)
      log_q.push_back(ad_e(4'h5, tbl_addr_reg));
    if (!sys_rst && ex_valid_reg)
      log_q.push_back(ex_e(ex_nop_reg, ex_from_tbl_reg, ex_ins_reg.kind, ex_ins_reg.code));
    if (!sys_rst && ref_fault_reg)
      log_q.push_back(ad_e(4'h4, 14'h0));
    if (!sys_rst && resume_reg)
      log_q.push_back(ad_e(4'h2, resume_addr_reg));
    if (!sys_rst && branch_reg)
      log_q.push_back(ad_e(call_push_reg ? 4'h7 : 4'h3, branch_addr_reg));
    if (!sys_rst && call_push_reg)
      log_q.push_back(ad_e(4'h6, ret_addr_reg));
    if (cyc == 4000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // offer one word and hold it until taken
  task automatic put(input trd_kind_t k, input logic [13:0] a, input logic [13:0] t);
    int n = 0;
    in_valid <= 1'b1;
    in_ins <= '{k, 16'h0, a, t};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (in_ready_reg !== 1'b1 && n < 40);
  endtask

  // release the stream and wait for the block to go idle
  task automatic drain();
    int n = 0;
    in_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    while (in_ready_reg !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
    `CHK(in_ready_reg, 1'b1)
  endtask

  task automatic exp_q(input logic [31:0] e);
    logic [31:0] g;
    g = 32'hFFFFFFFF;
    if (log_q.size() != 0)
      g = log_q.pop_front();
    `CHK(g, e)
  endtask

  task automatic s_runs();
    put(TRD_K_LD_ACC_IMM, 14'h100, 14'h0);
    put(TRD_K_LD_EXT_ACC_IMM, 14'h101, 14'h0);
    put(TRD_K_LD_PTR_IMM, 14'h102, 14'h0);
    put(TRD_K_LD_PTR_IMM, 14'h103, 14'h0);
    put(TRD_K_LD_ACC_IMM, 14'h104, 14'h0);
    put(TRD_K_OTHER, 14'h105, 14'h0);
    drain();
    exp_q(ex_e(0, 0, TRD_K_LD_ACC_IMM));
    exp_q(ex_e(1, 0, TRD_K_LD_EXT_ACC_IMM));
    exp_q(ex_e(0, 0, TRD_K_LD_PTR_IMM));
    exp_q(ex_e(1, 0, TRD_K_LD_PTR_IMM));
    exp_q(ex_e(0, 0, TRD_K_LD_ACC_IMM));
    exp_q(ex_e(0, 0, TRD_K_OTHER));
  endtask

  task automatic s_ref_load();
    put(TRD_K_LD_ACC_IMM, 14'h200, 14'h0);
    put(TRD_K_REF, 14'h201, 14'h20);
    put(TRD_K_LD_ACC_IMM, 14'h202, 14'h0);
    drain();
    exp_q(ex_e(0, 0, TRD_K_LD_ACC_IMM));
    exp_q(ad_e(4'h5, 14'h20));
    exp_q(ex_e(0, 1, TRD_K_LD_EXT_ACC_IMM, 16'hA530));
    exp_q(ad_e(4'h2, 14'h202));
    exp_q(ex_e(1, 0, TRD_K_LD_ACC_IMM));
  endtask

  task automatic s_ref_pair();
    skip_kind <= TRD_K_OTHER;
    put(TRD_K_LD_PTR_IMM, 14'h300, 14'h0);
    put(TRD_K_REF, 14'h301, 14'h22);
    put(TRD_K_LD_EXT_ACC_IMM, 14'h302, 14'h0);
    skip_kind <= TRD_K_TABLE_CALL;
    put(TRD_K_LD_ACC_IMM, 14'h303, 14'h0);
    drain();
    exp_q(ex_e(0, 0, TRD_K_LD_PTR_IMM));
    exp_q(ad_e(4'h5, 14'h22));
    exp_q(ex_e(0, 1, TRD_K_LD_ACC_IMM, 16'h9A12));
    exp_q(ex_e(0, 1, TRD_K_OTHER, 16'h9A12));
    exp_q(ad_e(4'h2, 14'h302));
    exp_q(ex_e(1, 0, TRD_K_LD_EXT_ACC_IMM));
    exp_q(ex_e(0, 0, TRD_K_LD_ACC_IMM));
  endtask

  task automatic s_ref_branch();
    put(TRD_K_REF, 14'h400, 14'h24);
    drain();
    put(TRD_K_REF, 14'h401, 14'h26);
    drain();
    exp_q(ad_e(4'h5, 14'h24));
    exp_q(ad_e(4'h3, 14'h1234));
    exp_q(ad_e(4'h5, 14'h26));
    exp_q(ad_e(4'h7, 14'h0456));
    exp_q(ad_e(4'h6, 14'h402));
  endtask

  // refused references: out of area, odd, exchange entry, msb-zero first
  task automatic s_ref_fault();
    logic [13:0] tg [5] = '{14'h1E, 14'h80, 14'h21, 14'h28, 14'h2A};
    logic [13:0] a;
    for (int i = 0; i < 5; i++)
    begin
      a = 14'h500 + 14'(i);
      put(TRD_K_REF, a, tg[i]);
      drain();
      if (i > 2)
        exp_q(ad_e(4'h5, tg[i]));
      exp_q(ad_e(4'h4, 14'h0));
      exp_q(ad_e(4'h2, a + 14'h1));
    end
  endtask

  task automatic s_skip_ref();
    skip_kind <= TRD_K_OTHER;
    put(TRD_K_OTHER, 14'h600, 14'h0);
    put(TRD_K_REF, 14'h601, 14'h20);
    skip_kind <= TRD_K_TABLE_CALL;
    put(TRD_K_LD_ACC_IMM, 14'h602, 14'h0);
    drain();
    exp_q(ex_e(0, 0, TRD_K_OTHER));
    exp_q(ex_e(1, 0, TRD_K_REF));
    exp_q(ex_e(0, 0, TRD_K_LD_ACC_IMM));
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    s_runs();
    s_ref_load();
    s_ref_pair();
    s_ref_branch();
    s_ref_fault();
    s_skip_ref();
    `CHK(log_q.size(), 0)
    tally_and_finish();
  end
endmodule
